// File: rtl/dd_alarm_chan.sv
// one alarm channel: static level or rate-of-change threshold compare
// assumes sample_tick_in pulses once per sensor sample cycle
`timescale 1ns/10ps
`default_nettype none

module dd_alarm_chan
  import dd_pkg::*;
#(
  parameter int DATA_W = DD_DATA_W,
  parameter int DEPTH  = DD_HIST_DEPTH
)
(
  input  wire logic              core_clk_in,
  input  wire logic              rst_in,
  input  wire logic              sample_tick_in,
  input  wire logic [DATA_W-1:0] sample_in,
  input  wire logic [15:0]       threshold_in,
  input  wire logic [7:0]        count_in,
  input  wire logic              change_rate_mode_in,
  input  wire logic              enable_in,
  output logic                   active_out
);

  // ****************************************************************
  // sample history
  // ****************************************************************
  // no reset on the history; the fill counter hides stale entries
  logic [DATA_W-1:0] hist [DEPTH];
  dd_chan_state_t    st;
  dd_chan_state_t    next_st;
  logic [7:0]        window;
  logic [DATA_W-1:0] old_sample;
  logic signed [DATA_W:0] value;
  logic signed [DATA_W:0] thresh;
  logic              hit;
  logic              primed;

  always_ff @(posedge core_clk_in)
  begin
    if (sample_tick_in)
    begin
      hist[st.wr_ptr] <= sample_in;
    end
  end

  // ****************************************************************
  // compare
  // ****************************************************************
  always_comb
  begin
    next_st    = st;
    // zero and one both mean a single sample
    window     = (count_in <= 8'h01) ? 8'h01 : count_in;
    old_sample = hist[8'(st.wr_ptr - window)];
    // rate mode compares the change across the window
    value      = change_rate_mode_in
               ? $signed({sample_in[DATA_W-1], sample_in})
                 - $signed({old_sample[DATA_W-1], old_sample})
               : $signed({sample_in[DATA_W-1], sample_in});
    thresh     = $signed({threshold_in[DD_THR_MSB],
                          threshold_in[DD_THR_MSB:0]});
    hit        = threshold_in[DD_THR_POL_BIT] ? (value > thresh)
                                              : (value < thresh);
    primed     = !change_rate_mode_in || (st.fill >= {1'b0, window});
    if (sample_tick_in)
    begin
      next_st.wr_ptr = st.wr_ptr + 8'h01;
      if (st.fill != 9'(DEPTH))
      begin
        next_st.fill = st.fill + 9'h001;
      end
      next_st.active = enable_in && primed && hit;
    end
  end

  always_ff @(posedge core_clk_in)
  begin
    if (rst_in)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign active_out = st.active;

  // ****************************************************************
  // checks
  // ****************************************************************
  a_disabled_quiet: assert property (@(posedge core_clk_in)
    disable iff (rst_in)
    sample_tick_in && !enable_in |=> !active_out)
    else $error("alarm active while its source is disabled");

endmodule

`default_nettype wire

// File: rtl/dd_monitor.sv
// diagnostic flag register and two-channel alarm monitor, top level
// assumes a decoded 16-bit register port and a one-cycle sample tick
//
// Function
// - reading the flag register clears every latched flag except supply flags
// - a condition still present sets its flag again on next sample
// - supply flags ignore reads and drop once supply returns in range
// - bits 15..13 accel z/y/x, 12..10 gyro x/y/z self-test failures
// - bit 9 shows alarm two active, bit 8 alarm one active
// - bits 6..2 flash sum, self-test, overrange, serial, flash update; 7 zero
// - bit 1 supply at or above upper limit, bit 0 at or below lower
// - two alarm channels evaluated independently with own settings
// - threshold bit 15 polarity, bits 13..0 threshold value, bit 14 unused
// - sample count in bits 7..0, zero and one both mean one sample
// - rate window equals sample count times the current sample period
// - configuration bits 15..12 choose alarm two source, zero disables
// - configuration bits 11..8 choose alarm one source, same codes
// - bits 7 and 6 select rate-of-change for alarm two and one
// - bit 4 selects filtered data for comparisons; bits 5 and 3 unused
// - incline sources always compare filtered data
// - bit 2 output enable, bit 1 polarity, bit 0 selects line two
// - flash checksum completion loads its verdict into flag bit 6
// - self-test completion reports verdicts and clears its trigger in the same cycle
`timescale 1ns/10ps
`default_nettype none

module dd_monitor
  import dd_pkg::*;
#(
  parameter int DATA_W = DD_DATA_W,
  parameter int DEPTH  = DD_HIST_DEPTH
)
(
  input  wire logic          core_clk_in,
  input  wire logic          rst_in,
  input  wire logic          sample_tick_in,
  input  wire logic [6:0]    reg_addr_in,
  input  wire logic          reg_wr_in,
  input  wire logic          reg_rd_in,
  input  wire logic [15:0]   reg_wdata_in,
  output logic [15:0]        reg_rdata_out,
  input  wire dd_src_set_t   raw_src_in,
  input  wire dd_src_set_t   filt_src_in,
  input  wire dd_cond_t      cond_in,
  input  wire logic          selftest_start_in,
  input  wire logic          selftest_done_in,
  input  wire dd_st_result_t selftest_result_in,
  input  wire logic          flash_check_done_in,
  input  wire logic          flash_check_fail_in,
  output logic               selftest_running_out,
  output logic               aux_io_line_one_out,
  output logic               aux_io_line_one_oe_out,
  output logic               aux_io_line_two_out,
  output logic               aux_io_line_two_oe_out
);

  // ****************************************************************
  // alarm channels
  // ****************************************************************
  dd_state_t  st;
  dd_state_t  next_st;
  logic [1:0] alarm_active;
  logic [3:0] src_code [2];
  logic [1:0] roc_sel;
  logic [1:0][15:0] thr_sel;
  logic [1:0][15:0] cnt_sel;

  assign src_code[0] = st.alarm_cfg[DD_CFG_SRC1_LSB +: 4];
  assign src_code[1] = st.alarm_cfg[DD_CFG_SRC2_LSB +: 4];
  assign roc_sel     = {st.alarm_cfg[DD_CFG_ROC2_BIT],
                        st.alarm_cfg[DD_CFG_ROC1_BIT]};
  assign thr_sel     = {st.thresh_two, st.thresh_one};
  assign cnt_sel     = {st.count_two, st.count_one};

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++)
    begin : g_chan
      logic              use_filt;
      logic              src_on;
      logic [DATA_W-1:0] sample;
      // inclines have no unfiltered path worth alarming on
      assign use_filt = st.alarm_cfg[DD_CFG_FILT_BIT]
                     || src_code[gi] == DD_SRC_INCL_X
                     || src_code[gi] == DD_SRC_INCL_Y;
      assign src_on   = src_code[gi] != DD_SRC_OFF
                     && src_code[gi] <= DD_SRC_LAST;
      assign sample   = use_filt ? filt_src_in[src_code[gi]]
                                 : raw_src_in[src_code[gi]];
      dd_alarm_chan #(
        .DATA_W (DATA_W),
        .DEPTH  (DEPTH)
      ) u_chan (
        .core_clk_in         (core_clk_in),
        .rst_in              (rst_in),
        .sample_tick_in      (sample_tick_in),
        .sample_in           (sample),
        .threshold_in        (thr_sel[gi]),
        .count_in            (cnt_sel[gi][7:0]),
        .change_rate_mode_in (roc_sel[gi]),
        .enable_in           (src_on),
        .active_out          (alarm_active[gi])
      );
    end
  endgenerate

  // ****************************************************************
  // registers and flags
  // ****************************************************************
  logic        rd_flags;
  logic [15:0] set_flags;
  logic        any_alarm;
  logic        io_level;

  always_comb
  begin
    next_st   = st;
    rd_flags  = reg_rd_in && reg_addr_in == DD_ADDR_DIAG_FLAGS;
    set_flags = '0;
    if (sample_tick_in)
    begin
      // held conditions come back each sample after a clearing read
      set_flags[DD_FLG_GYR_Z +: 6]  = st.st_result.axis_fail;
      set_flags[DD_FLG_ST_DIAG]     = st.st_result.diag_fail;
      set_flags[DD_FLG_FLASH_SUM]   = st.flash_fail;
      set_flags[DD_FLG_OVERRANGE]   = cond_in.overrange;
    end
    set_flags[DD_FLG_ALARM1 +: 2]   = alarm_active;
    set_flags[DD_FLG_SPI_FAIL]      = cond_in.spi_fail;
    set_flags[DD_FLG_FLASH_UPD]     = cond_in.flash_upd_fail;
    if (flash_check_done_in)
    begin
      next_st.flash_fail           = flash_check_fail_in;
      set_flags[DD_FLG_FLASH_SUM]  = flash_check_fail_in;
    end
    if (selftest_done_in)
    begin
      next_st.st_result            = selftest_result_in;
      set_flags[DD_FLG_GYR_Z +: 6] = selftest_result_in.axis_fail;
      set_flags[DD_FLG_ST_DIAG]    = selftest_result_in.diag_fail;
    end
    // a set in the clearing cycle wins over the read
    next_st.flags = (rd_flags ? (st.flags & DD_MASK_KEEP_ON_RD)
                              : st.flags) | set_flags;
    next_st.flags[DD_FLG_FLASH_SUM] = flash_check_done_in
                                    ? flash_check_fail_in
                                    : next_st.flags[DD_FLG_FLASH_SUM];
    if (sample_tick_in)
    begin
      next_st.flags[DD_FLG_SUP_HIGH] = cond_in.supply_high;
      next_st.flags[DD_FLG_SUP_LOW]  = cond_in.supply_low;
    end
    next_st.flags[7] = 1'b0;

    if (selftest_done_in)
    begin
      next_st.st_running = 1'b0;
    end
    else if (selftest_start_in)
    begin
      next_st.st_running = 1'b1;
    end

    if (reg_wr_in)
    begin
      unique case (reg_addr_in)
        DD_ADDR_THRESH_ONE: next_st.thresh_one = reg_wdata_in & DD_MASK_THRESH;
        DD_ADDR_THRESH_TWO: next_st.thresh_two = reg_wdata_in & DD_MASK_THRESH;
        DD_ADDR_COUNT_ONE:  next_st.count_one  = reg_wdata_in & DD_MASK_COUNT;
        DD_ADDR_COUNT_TWO:  next_st.count_two  = reg_wdata_in & DD_MASK_COUNT;
        DD_ADDR_ALARM_CFG:  next_st.alarm_cfg  = reg_wdata_in
                                               & DD_MASK_ALARM_CFG;
        default:            next_st.flags      = next_st.flags;
      endcase
    end

    if (reg_rd_in)
    begin
      unique case (reg_addr_in)
        DD_ADDR_THRESH_ONE: next_st.rdata = st.thresh_one;
        DD_ADDR_THRESH_TWO: next_st.rdata = st.thresh_two;
        DD_ADDR_COUNT_ONE:  next_st.rdata = st.count_one;
        DD_ADDR_COUNT_TWO:  next_st.rdata = st.count_two;
        DD_ADDR_ALARM_CFG:  next_st.rdata = st.alarm_cfg;
        DD_ADDR_DIAG_FLAGS: next_st.rdata = st.flags;
        default:            next_st.rdata = 16'h0000;
      endcase
    end

    // ****************************************************************
    // alarm output line
    // ****************************************************************
    any_alarm = |alarm_active;
    io_level  = st.alarm_cfg[DD_CFG_OUT_POL_BIT] ? any_alarm : !any_alarm;
    next_st.io_one    = 1'b0;
    next_st.io_one_oe = 1'b0;
    next_st.io_two    = 1'b0;
    next_st.io_two_oe = 1'b0;
    if (st.alarm_cfg[DD_CFG_OUT_EN_BIT])
    begin
      if (st.alarm_cfg[DD_CFG_OUT_SEL_BIT])
      begin
        next_st.io_two    = io_level;
        next_st.io_two_oe = 1'b1;
      end
      else
      begin
        next_st.io_one    = io_level;
        next_st.io_one_oe = 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk_in)
  begin
    if (rst_in)
    begin
      st            <= '0;
      st.thresh_one <= DD_RST_THRESH;
      st.thresh_two <= DD_RST_THRESH;
      st.count_one  <= DD_RST_COUNT;
      st.count_two  <= DD_RST_COUNT;
      st.alarm_cfg  <= DD_RST_ALARM_CFG;
      st.flags      <= DD_RST_FLAGS;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign reg_rdata_out          = st.rdata;
  assign selftest_running_out   = st.st_running;
  assign aux_io_line_one_out    = st.io_one;
  assign aux_io_line_one_oe_out = st.io_one_oe;
  assign aux_io_line_two_out    = st.io_two;
  assign aux_io_line_two_oe_out = st.io_two_oe;

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking dd_cb @(posedge core_clk_in);
  endclocking
  default disable iff (rst_in);

  a_read_clears: assert property (
    rd_flags && !sample_tick_in && !selftest_done_in
    && !flash_check_done_in && !cond_in.spi_fail
    && !cond_in.flash_upd_fail && alarm_active == 2'b00
    |=> st.flags[15:2] == 14'h0000)
    else $error("flag read did not clear latched flags");
  a_supply_kept: assert property (
    rd_flags && !sample_tick_in |=> st.flags[1:0] == $past(st.flags[1:0]))
    else $error("supply flags changed on a read");
  a_supply_live: assert property (
    sample_tick_in |=> st.flags[1:0]
      == {$past(cond_in.supply_high), $past(cond_in.supply_low)})
    else $error("supply flags do not follow supply");
  a_cond_reasserts: assert property (
    sample_tick_in && cond_in.overrange |=> st.flags[DD_FLG_OVERRANGE])
    else $error("overrange flag lost while condition holds");
  a_alarm_flags: assert property (
    alarm_active[1] |=> st.flags[9])
    else $error("alarm two active but flag clear");
  a_alarm_one_flag: assert property (
    alarm_active[0] |=> st.flags[8])
    else $error("alarm one active but flag clear");
  a_flash_load: assert property (
    flash_check_done_in |=> st.flags[DD_FLG_FLASH_SUM]
      == $past(flash_check_fail_in))
    else $error("flash verdict not loaded");
  a_selftest_ends: assert property (
    selftest_done_in |=> !selftest_running_out
      && ((st.flags[15:10] & $past(selftest_result_in.axis_fail))
          == $past(selftest_result_in.axis_fail)))
    else $error("self-test trigger not cleared");
  a_st_start: assert property (
    selftest_start_in && !selftest_done_in |=> selftest_running_out)
    else $error("self-test trigger not raised");
  a_flag_readback: assert property (
    rd_flags |=> reg_rdata_out == $past(st.flags))
    else $error("flag read returned wrong data");
  // level follows the polarity bit, so active-low setups are checked too
  a_io_level: assert property (
    st.alarm_cfg[DD_CFG_OUT_EN_BIT] && !st.alarm_cfg[DD_CFG_OUT_SEL_BIT]
    |=> aux_io_line_one_oe_out && !aux_io_line_two_oe_out
      && aux_io_line_one_out
      == ($past(st.alarm_cfg[DD_CFG_OUT_POL_BIT]) ~^ $past(|alarm_active)))
    else $error("alarm output level wrong");
  a_io_line_two: assert property (
    st.alarm_cfg[DD_CFG_OUT_EN_BIT] && st.alarm_cfg[DD_CFG_OUT_SEL_BIT]
    |=> aux_io_line_two_oe_out && !aux_io_line_one_oe_out
      && aux_io_line_two_out
      == ($past(st.alarm_cfg[DD_CFG_OUT_POL_BIT]) ~^ $past(|alarm_active)))
    else $error("alarm output level wrong on second line");
  a_io_disabled: assert property (
    !st.alarm_cfg[DD_CFG_OUT_EN_BIT]
    |=> !aux_io_line_one_oe_out && !aux_io_line_two_oe_out)
    else $error("alarm output driven while disabled");
  a_bit7_zero: assert property (
    st.flags[7] == 1'b0)
    else $error("unused flag bit set");

  c_read_clear: cover property (rd_flags && st.flags[15:2] != 14'h0000);
  c_roc_alarm:  cover property (roc_sel[1] && alarm_active[1]);
  c_line_two:   cover property (aux_io_line_two_oe_out && aux_io_line_two_out);

endmodule

`default_nettype wire

// File: rtl/dd_pkg.sv
// diagnostic status and alarm monitor: shared constants and types
// assumes a 16-bit register port decoded from the serial link outside
package dd_pkg;

  // ****************************************************************
  // register map (byte address of each 16-bit word)
  // ****************************************************************
  localparam logic [6:0] DD_ADDR_THRESH_ONE  = 7'h26;
  localparam logic [6:0] DD_ADDR_THRESH_TWO  = 7'h28;
  localparam logic [6:0] DD_ADDR_COUNT_ONE   = 7'h2a;
  localparam logic [6:0] DD_ADDR_COUNT_TWO   = 7'h2c;
  localparam logic [6:0] DD_ADDR_ALARM_CFG   = 7'h2e;
  localparam logic [6:0] DD_ADDR_DIAG_FLAGS  = 7'h3c;

  // ****************************************************************
  // reset values and write masks
  // ****************************************************************
  localparam logic [15:0] DD_RST_THRESH      = 16'h0000;
  localparam logic [15:0] DD_RST_COUNT       = 16'h0000;
  localparam logic [15:0] DD_RST_ALARM_CFG   = 16'h0000;
  localparam logic [15:0] DD_RST_FLAGS       = 16'h0000;
  localparam logic [15:0] DD_MASK_THRESH     = 16'hbfff;
  localparam logic [15:0] DD_MASK_COUNT      = 16'h00ff;
  localparam logic [15:0] DD_MASK_ALARM_CFG  = 16'hffd7;
  // supply flags follow the supply, every other flag clears on read
  localparam logic [15:0] DD_MASK_KEEP_ON_RD = 16'h0003;

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int DD_THR_POL_BIT    = 15;
  localparam int DD_THR_MSB        = 13;
  localparam int DD_CFG_SRC2_LSB   = 12;
  localparam int DD_CFG_SRC1_LSB   = 8;
  localparam int DD_CFG_ROC2_BIT   = 7;
  localparam int DD_CFG_ROC1_BIT   = 6;
  localparam int DD_CFG_FILT_BIT   = 4;
  localparam int DD_CFG_OUT_EN_BIT = 2;
  localparam int DD_CFG_OUT_POL_BIT = 1;
  localparam int DD_CFG_OUT_SEL_BIT = 0;
  localparam int DD_FLG_ACC_Z      = 15;
  localparam int DD_FLG_GYR_Z      = 10;
  localparam int DD_FLG_ALARM1     = 8;
  localparam int DD_FLG_FLASH_SUM  = 6;
  localparam int DD_FLG_ST_DIAG    = 5;
  localparam int DD_FLG_OVERRANGE  = 4;
  localparam int DD_FLG_SPI_FAIL   = 3;
  localparam int DD_FLG_FLASH_UPD  = 2;
  localparam int DD_FLG_SUP_HIGH   = 1;
  localparam int DD_FLG_SUP_LOW    = 0;

  // ****************************************************************
  // alarm sources and widths
  // ****************************************************************
  localparam int         DD_DATA_W     = 14;
  localparam int         DD_HIST_DEPTH = 256;
  localparam int         DD_NUM_SRC    = 12;
  localparam logic [3:0] DD_SRC_OFF    = 4'h0;
  localparam logic [3:0] DD_SRC_INCL_X = 4'h9;
  localparam logic [3:0] DD_SRC_INCL_Y = 4'ha;
  localparam logic [3:0] DD_SRC_LAST   = 4'hb;

  typedef logic [DD_DATA_W-1:0] dd_word_t;
  // index is the source code; entry 0 is unused
  typedef logic [DD_NUM_SRC-1:0][DD_DATA_W-1:0] dd_src_set_t;

  typedef struct packed {
    logic supply_high;
    logic supply_low;
    logic overrange;
    logic spi_fail;
    logic flash_upd_fail;
  } dd_cond_t;

  // self-test verdicts, accel z/y/x, gyro x/y/z, diagnostic error
  typedef struct packed {
    logic [5:0] axis_fail;
    logic       diag_fail;
  } dd_st_result_t;

  typedef struct packed {
    logic [7:0] wr_ptr;
    logic [8:0] fill;
    logic       active;
  } dd_chan_state_t;

  typedef struct packed {
    logic [15:0]   thresh_one;
    logic [15:0]   thresh_two;
    logic [15:0]   count_one;
    logic [15:0]   count_two;
    logic [15:0]   alarm_cfg;
    logic [15:0]   flags;
    logic [15:0]   rdata;
    dd_st_result_t st_result;
    logic          flash_fail;
    logic          st_running;
    logic          io_one;
    logic          io_one_oe;
    logic          io_two;
    logic          io_two_oe;
  } dd_state_t;

endpackage

// File: test/dd_host_model.sv
// host processor model: single 16-bit register reads and writes
// assumes the monitor takes strobes on the rising clock edge
`timescale 1ns/10ps
`default_nettype none

module dd_host_model
(
  input  wire logic        clk_in,
  input  wire logic [15:0] rdata_in,
  output logic      [6:0]  addr_out,
  output logic             wr_out,
  output logic             rd_out,
  output logic      [15:0] wdata_out
);
  // ****************************************************************
  // idle bus
  // ****************************************************************
  initial
  begin
    addr_out  = 7'h7f;
    wdata_out = 16'h0000;
    wr_out    = 1'b0;
    rd_out    = 1'b0;
  end

  // ****************************************************************
  // transfers, launched and released on falling edges
  // ****************************************************************
  // released lines show the inverse so a stale value never matches
  task automatic wr(input logic [6:0] a, input logic [15:0] d);
    @(negedge clk_in);
    addr_out  = a;
    wdata_out = d;
    wr_out    = 1'b1;
    @(negedge clk_in);
    wr_out    = 1'b0;
    addr_out  = ~a;
    wdata_out = ~d;
  endtask

  task automatic rd(input logic [6:0] a, output logic [15:0] d);
    @(negedge clk_in);
    addr_out = a;
    rd_out   = 1'b1;
    @(negedge clk_in);
    rd_out   = 1'b0;
    addr_out = ~a;
    d        = rdata_in;
  endtask
endmodule

`default_nettype wire

// File: test/test_dd_monitor.sv
// testbench for the diagnostic flag and alarm monitor
// assumes the host model drives the register port on falling edges
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin n_errors++; \
  $display("[FAIL] %0t got %h want %h", $time, a, e); end end

module test_dd_monitor import dd_pkg::*;;
  logic          clk = 1'b0;
  logic          rst = 1'b1;
  logic          tick = 1'b0;
  logic          st_go = 1'b0;
  logic          st_end = 1'b0;
  logic          fl_end = 1'b0;
  logic          fl_bad = 1'b0;
  dd_st_result_t st_res = '0;
  dd_cond_t      cond = '0;
  dd_src_set_t   raw = '0;
  dd_src_set_t   filt = '0;
  logic [6:0]    addr;
  logic          wr, rd, running, io1, io1_oe, io2, io2_oe;
  logic [15:0]   wdata, rdata;
  int            n_errors = 0;
  int            tests_run = 0;
  logic [6:0]    adr [5] = '{7'h26, 7'h28, 7'h2a, 7'h2c, 7'h2e};
  logic [15:0]   msk [5] = '{16'hbfff, 16'hbfff, 16'h00ff, 16'h00ff,
                             16'hffd7};
  localparam logic [6:0] FLG = DD_ADDR_DIAG_FLAGS;

  always #2.5 clk = ~clk;

  dd_monitor u_dd_monitor (
    .core_clk_in            (clk),
    .rst_in                 (rst),
    .sample_tick_in         (tick),
    .reg_addr_in            (addr),
    .reg_wr_in              (wr),
    .reg_rd_in              (rd),
    .reg_wdata_in           (wdata),
    .reg_rdata_out          (rdata),
    .raw_src_in             (raw),
    .filt_src_in            (filt),
    .cond_in                (cond),
    .selftest_start_in      (st_go),
    .selftest_done_in       (st_end),
    .selftest_result_in     (st_res),
    .flash_check_done_in    (fl_end),
    .flash_check_fail_in    (fl_bad),
    .selftest_running_out   (running),
    .aux_io_line_one_out    (io1),
    .aux_io_line_one_oe_out (io1_oe),
    .aux_io_line_two_out    (io2),
    .aux_io_line_two_oe_out (io2_oe)
  );

  dd_host_model u_dd_host_model (
    .clk_in    (clk),
    .rdata_in  (rdata),
    .addr_out  (addr),
    .wr_out    (wr),
    .rd_out    (rd),
    .wdata_out (wdata)
  );

  // ****************************************************************
  // shared steps
  // ****************************************************************
  task automatic wrr(input logic [6:0] a, input logic [15:0] d);
    u_dd_host_model.wr(a, d);
  endtask

  task automatic rdchk(input logic [6:0] a, input logic [15:0] e);
    logic [15:0] d;
    u_dd_host_model.rd(a, d);
    `CHK(d, e)
  endtask

  // ends two edges after the tick so alarm outputs have landed
  task automatic pulse_tick();
    @(negedge clk);
    tick = 1'b1;
    @(negedge clk);
    tick = 1'b0;
    @(negedge clk);
  endtask

  task automatic pulse_st(input logic [6:0] r);
    st_res = dd_st_result_t'(r);
    st_end = 1'b1;
    @(negedge clk);
    st_end = 1'b0;
  endtask

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_regs();
    for (int i = 0; i < 5; i++)
    begin
      rdchk(adr[i], 16'h0000);
      wrr(adr[i], 16'hffff);
      rdchk(adr[i], msk[i]);
      wrr(adr[i], 16'h0000);
    end
    wrr(FLG, 16'hffff);
    rdchk(FLG, 16'h0000);
    rdchk(7'h00, 16'h0000);
    $display("t_regs done");
  endtask

  task automatic t_flags();
    cond = dd_cond_t'(5'b10100);
    pulse_tick();
    rdchk(FLG, 16'h0012);
    cond.overrange = 1'b0;
    rdchk(FLG, 16'h0002);
    cond.overrange = 1'b1;
    pulse_tick();
    rdchk(FLG, 16'h0012);
    cond = dd_cond_t'(5'b01011);
    pulse_tick();
    cond = '0;
    rdchk(FLG, 16'h000d);
    pulse_tick();
    rdchk(FLG, 16'h0000);
    $display("t_flags done");
  endtask

  task automatic t_tests();
    fl_bad = 1'b1;
    fl_end = 1'b1;
    @(negedge clk);
    fl_end = 1'b0;
    rdchk(FLG, 16'h0040);
    st_go = 1'b1;
    @(negedge clk);
    st_go = 1'b0;
    `CHK(running, 1'b1)
    pulse_st(7'b1011011);
    `CHK(running, 1'b0)
    rdchk(FLG, 16'hb420);
    pulse_tick();
    rdchk(FLG, 16'hb460);
    fl_bad = 1'b0;
    fl_end = 1'b1;
    pulse_st(7'b0000000);
    fl_end = 1'b0;
    pulse_tick();
    rdchk(FLG, 16'h0000);
    $display("t_tests done");
  endtask

  // filtered copies stay zero, so an alarm here proves raw data is used
  task automatic t_static();
    wrr(DD_ADDR_THRESH_ONE, 16'h8064);
    wrr(DD_ADDR_THRESH_TWO, 16'h0032);
    wrr(DD_ADDR_ALARM_CFG, 16'h7507);
    raw[5] = 14'd200;
    raw[7] = 14'd100;
    pulse_tick();
    `CHK({io2_oe, io2, io1_oe}, 3'b110)
    rdchk(FLG, 16'h0100);
    raw[7] = 14'h3fff;
    pulse_tick();
    rdchk(FLG, 16'h0300);
    raw[5] = 14'd50;
    raw[7] = 14'd100;
    pulse_tick();
    `CHK({io2_oe, io2}, 2'b10)
    // raw data now trips nothing; only the zero filtered copy can
    wrr(DD_ADDR_ALARM_CFG, 16'h7517);
    pulse_tick();
    `CHK({io2_oe, io2}, 2'b11)
    $display("t_static done");
  endtask

  // incline source with filter bit clear: only filtered data moves
  task automatic t_rate();
    wrr(DD_ADDR_THRESH_TWO, 16'h800a);
    wrr(DD_ADDR_COUNT_TWO, 16'h0002);
    wrr(DD_ADDR_ALARM_CFG, 16'h9084);
    repeat (3) pulse_tick();
    `CHK({io1_oe, io1, io2_oe}, 3'b110)
    filt[9] = 14'd20;
    pulse_tick();
    `CHK(io1, 1'b0)
    pulse_tick();
    `CHK(io1, 1'b0)
    pulse_tick();
    `CHK(io1, 1'b1)
    wrr(DD_ADDR_COUNT_TWO, 16'h0000);
    filt[9] = 14'd40;
    pulse_tick();
    `CHK(io1, 1'b0)
    pulse_tick();
    `CHK(io1, 1'b1)
    $display("t_rate done");
  endtask

  // ****************************************************************
  // run control
  // ****************************************************************
  task automatic test_done();
    $display("tests_run %0d n_errors %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // scenarios need well under 1000 cycles
  initial
  begin
    repeat (20000) @(posedge clk);
    n_errors++;
    $display("[FAIL] %0t watchdog expired", $time);
    test_done();
  end

  initial
  begin
    repeat (12) @(negedge clk);
    rst = 1'b0;
    t_regs();
    t_flags();
    t_tests();
    t_static();
    t_rate();
    test_done();
  end
endmodule

`default_nettype wire
